// file: logic/sdac_defs.svh
// offsets, field positions, reset values and timing counts for the converter control
`ifndef SDAC_DEFS_SVH
`define SDAC_DEFS_SVH
`define SDAC_ADDR_CTL0 4'h0
`define SDAC_ADDR_CTL1 4'h1
`define SDAC_ADDR_DIV 4'h2
`define SDAC_ADDR_RES_LO 4'h3
`define SDAC_ADDR_RES_MID 4'h4
`define SDAC_ADDR_RES_HI 4'h5
`define SDAC_ADDR_CHAN 4'h6
`define SDAC_CTL0_RESET 8'h20
`define SDAC_CTL0_MASK 8'hfd
`define SDAC_CTL1_MASK 8'hfe
`define SDAC_DIV_MASK 8'h1f
`define SDAC_CHAN_MASK 8'hff
`define SDAC_BIT_FRST 7
`define SDAC_BIT_SLEEP 6
`define SDAC_BIT_POFF 5
`define SDAC_BIT_REFSEL 0
`define SDAC_BIT_NBUF 4
`define SDAC_BIT_PBUF 3
`define SDAC_BIT_HOLD 2
`define SDAC_BIT_EOC 1
`define SDAC_BIT_CHOP1 7
`define SDAC_BIT_DIV12 6
`define SDAC_OSR_HI 4
`define SDAC_OSR_LO 2
`define SDAC_DIV_BYPASS 5'h1f
`define SDAC_TEMP_SENSOR_CODE 4'hc
`define SDAC_OSR_MAX_LOG2 14
`define SDAC_DIV_SLOW 5'h1e
`define SDAC_DIV_FAST 5'h0c
`endif

// file: logic/sdac_pkg.sv
// types shared by the converter control logic
package sdac_pkg;
  typedef enum logic [1:0] {
    SDAC_MODE_DOWN = 2'b00,
    SDAC_MODE_SLEEP = 2'b01,
    SDAC_MODE_NORMAL = 2'b10,
    SDAC_MODE_RESET = 2'b11
  } sdac_mode_t;
  typedef struct packed {
    logic bandgap_on;
    logic regulator_on;
    logic common_mode_on;
    logic gain_amp_on;
    logic modulator_on;
    logic temp_sensor_on;
    logic neg_ref_buffer_on;
    logic pos_ref_buffer_on;
    logic filter_on;
    logic filter_reset;
    logic external_ref;
    logic factor_a_double;
  } sdac_power_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sdac_bus_t;
endpackage : sdac_pkg

// file: logic/sdac_ctrl.sv
// control registers, clock divider, mode decode and result path of the converter
`timescale 1ns/1ps
`include "sdac_defs.svh"
module sdac_ctrl #(
  parameter int DATA_W = 24
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire sdac_pkg::sdac_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_regulator_enable,
  input wire logic [DATA_W-1:0] i_filter_data,
  output sdac_pkg::sdac_mode_t o_mode,
  output sdac_pkg::sdac_power_t o_power,
  output logic o_modulator_clk_en,
  output logic o_conversion_clk_en,
  output logic o_irq_request
);
  import sdac_pkg::*;

  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] div_q;
  logic [7:0] chan_q;
  logic [DATA_W-1:0] result_q;
  logic [7:0] rdata_q;
  logic [5:0] mclk_cnt_q;
  logic mclk_en_q;
  logic [4:0] ack_cnt_q;
  logic ack_en_q;
  logic [13:0] dec_cnt_q;
  logic conv_done_q;
  logic irq_q;
  logic [4:0] div_code;
  logic [4:0] ack_div;
  logic [13:0] dec_last;
  logic [2:0] osr_code;
  logic frst;
  logic running;
  logic eoc_set;
  logic hold;
  sdac_mode_t mode;
  sdac_power_t pwr;

  assign frst = ctl0_q[`SDAC_BIT_FRST];
  assign hold = ctl1_q[`SDAC_BIT_HOLD];
  assign div_code = div_q[4:0];
  assign osr_code = ctl0_q[`SDAC_OSR_HI:`SDAC_OSR_LO];

  always_comb begin
    if (ctl0_q[`SDAC_BIT_POFF]) begin
      mode = SDAC_MODE_DOWN;
    end else if (ctl0_q[`SDAC_BIT_SLEEP]) begin
      mode = SDAC_MODE_SLEEP;
    end else if (frst) begin
      mode = SDAC_MODE_RESET;
    end else begin
      mode = SDAC_MODE_NORMAL;
    end
  end

  always_comb begin
    logic active;
    logic temp_sel;
    active = (mode == SDAC_MODE_NORMAL) || (mode == SDAC_MODE_RESET);
    temp_sel = (chan_q[7:4] == `SDAC_TEMP_SENSOR_CODE) ||
               (chan_q[3:0] == `SDAC_TEMP_SENSOR_CODE);
    pwr = '0;
    pwr.bandgap_on = (mode != SDAC_MODE_DOWN) || i_regulator_enable;
    pwr.common_mode_on = pwr.bandgap_on;
    pwr.regulator_on = i_regulator_enable;
    pwr.gain_amp_on = (mode != SDAC_MODE_DOWN);
    pwr.modulator_on = active;
    pwr.temp_sensor_on = active && temp_sel;
    pwr.neg_ref_buffer_on = active && ctl1_q[`SDAC_BIT_NBUF];
    pwr.pos_ref_buffer_on = active && ctl1_q[`SDAC_BIT_PBUF];
    pwr.filter_on = (mode != SDAC_MODE_DOWN);
    pwr.filter_reset = (mode == SDAC_MODE_RESET);
    pwr.external_ref = ctl0_q[`SDAC_BIT_REFSEL];
    pwr.factor_a_double = ~ctl1_q[`SDAC_BIT_CHOP1];
  end

  assign running = (mode == SDAC_MODE_NORMAL);

  // conversion clock divide 30 or 12
  assign ack_div = ctl1_q[`SDAC_BIT_DIV12] ? `SDAC_DIV_FAST : `SDAC_DIV_SLOW;

  assign dec_last = 14'((32'd1 << (`SDAC_OSR_MAX_LOG2 - 32'(osr_code))) - 32'd1);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mclk_cnt_q <= '0;
      mclk_en_q <= 1'b0;
    end else if (div_code == `SDAC_DIV_BYPASS) begin
      mclk_cnt_q <= '0;
      mclk_en_q <= 1'b1;
    end else if (mclk_cnt_q >= 6'(({1'b0, div_code} << 1) + 6'd1)) begin
      // six bits: code 30 needs a count of 61
      mclk_cnt_q <= '0;
      mclk_en_q <= 1'b1;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 6'd1;
      mclk_en_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ack_cnt_q <= '0;
      ack_en_q <= 1'b0;
    end else if (!mclk_en_q) begin
      ack_en_q <= 1'b0;
    end else if (ack_cnt_q >= ack_div - 5'd1) begin
      ack_cnt_q <= '0;
      ack_en_q <= 1'b1;
    end else begin
      ack_cnt_q <= ack_cnt_q + 5'd1;
      ack_en_q <= 1'b0;
    end
  end

  // decimation counter, cleared by filter reset
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dec_cnt_q <= '0;
      conv_done_q <= 1'b0;
    end else if (!running) begin
      dec_cnt_q <= '0;
      conv_done_q <= 1'b0;
    end else if (ack_en_q) begin
      conv_done_q <= (dec_cnt_q >= dec_last);
      dec_cnt_q <= (dec_cnt_q >= dec_last) ? 14'd0 : dec_cnt_q + 14'd1;
    end else begin
      conv_done_q <= 1'b0;
    end
  end

  assign eoc_set = conv_done_q && !hold;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      result_q <= '0;
    end else if (eoc_set) begin
      result_q <= i_filter_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctl0_q <= `SDAC_CTL0_RESET;
      div_q <= '0;
      chan_q <= '0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `SDAC_ADDR_CTL0) ctl0_q <= i_bus.wdata & `SDAC_CTL0_MASK;
      if (i_bus.addr == `SDAC_ADDR_DIV) div_q <= i_bus.wdata & `SDAC_DIV_MASK;
      if (i_bus.addr == `SDAC_ADDR_CHAN) chan_q <= i_bus.wdata & `SDAC_CHAN_MASK;
    end
  end

  // end flag: hardware set beats software write
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctl1_q <= '0;
    end else begin
      if (i_bus.wr && i_bus.addr == `SDAC_ADDR_CTL1) begin
        ctl1_q <= i_bus.wdata & `SDAC_CTL1_MASK;
      end
      if (eoc_set) begin
        ctl1_q[`SDAC_BIT_EOC] <= 1'b1;
      end
    end
  end

  // interrupt request pulse on end flag set
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= eoc_set;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_q <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        `SDAC_ADDR_CTL0: rdata_q <= ctl0_q;
        `SDAC_ADDR_CTL1: rdata_q <= ctl1_q;
        `SDAC_ADDR_DIV: rdata_q <= div_q;
        `SDAC_ADDR_RES_LO: rdata_q <= result_q[7:0];
        `SDAC_ADDR_RES_MID: rdata_q <= result_q[15:8];
        `SDAC_ADDR_RES_HI: rdata_q <= result_q[23:16];
        `SDAC_ADDR_CHAN: rdata_q <= chan_q;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_mode = mode;
  assign o_power = pwr;
  assign o_modulator_clk_en = mclk_en_q;
  assign o_conversion_clk_en = ack_en_q;
  assign o_irq_request = irq_q;

  chk_power_off_wins: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    ctl0_q[`SDAC_BIT_POFF] |-> (o_mode == SDAC_MODE_DOWN) && !o_power.modulator_on)
    else $error("power-off did not force power-down");
  chk_sleep_mode_off: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_mode == SDAC_MODE_SLEEP |-> o_power.gain_amp_on && o_power.bandgap_on
      && !o_power.modulator_on && !o_power.temp_sensor_on)
    else $error("sleep mode enables wrong");
  chk_filter_reset_hold: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    frst |=> !conv_done_q)
    else $error("conversion ended during filter reset");
  chk_eoc_sticky: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    ctl1_q[`SDAC_BIT_EOC] && !(i_bus.wr && i_bus.addr == `SDAC_ADDR_CTL1)
      |=> ctl1_q[`SDAC_BIT_EOC])
    else $error("end flag cleared by hardware");
  chk_hold_no_irq: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    hold && $stable(hold) |=> !o_irq_request)
    else $error("interrupt while result held");
  chk_hold_result: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    hold |=> $stable(result_q))
    else $error("result changed while held");
  chk_reserved_zero: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !ctl0_q[1] && !ctl1_q[0] && (div_q[7:5] == 3'h0))
    else $error("reserved bit set");
  chk_irq_follows_eoc: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    eoc_set |=> o_irq_request && ctl1_q[`SDAC_BIT_EOC])
    else $error("end flag set without interrupt request");
  chk_temp_mode: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_power.temp_sensor_on |-> o_mode inside {SDAC_MODE_NORMAL, SDAC_MODE_RESET})
    else $error("temperature sensor on outside active modes");
  chk_bypass_clock: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (div_code == `SDAC_DIV_BYPASS) [*2] |-> o_modulator_clk_en)
    else $error("bypass code did not pass system clock");
  cov_conversion: cover property (@(posedge i_core_clk) eoc_set);
  cov_sleep: cover property (@(posedge i_core_clk) o_mode == SDAC_MODE_SLEEP);
  cov_held: cover property (@(posedge i_core_clk) hold && conv_done_q);
  cov_reset_mode: cover property (@(posedge i_core_clk) o_mode == SDAC_MODE_RESET);
  cov_down_regulated: cover property (@(posedge i_core_clk)
    o_mode == SDAC_MODE_DOWN && i_regulator_enable);

  chk_sleep_decode: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !ctl0_q[`SDAC_BIT_POFF] && ctl0_q[`SDAC_BIT_SLEEP] |-> o_mode == SDAC_MODE_SLEEP)
    else $error("sleep control did not give sleep mode");

  chk_normal_decode: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !ctl0_q[`SDAC_BIT_POFF] && !ctl0_q[`SDAC_BIT_SLEEP] && !frst
      |-> o_mode == SDAC_MODE_NORMAL)
    else $error("clear controls did not give normal mode");

  chk_reset_filter: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_mode == SDAC_MODE_RESET |-> o_power.filter_reset && o_power.modulator_on)
    else $error("reset mode did not reset the filter");

  chk_sleep_filter_on: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_mode == SDAC_MODE_SLEEP |-> o_power.filter_on && !o_power.filter_reset)
    else $error("filter not kept on in sleep");

  chk_down_supplies: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_mode == SDAC_MODE_DOWN && !i_regulator_enable
      |-> !o_power.bandgap_on && !o_power.regulator_on && !o_power.common_mode_on)
    else $error("supplies left on in unregulated power-down");

  chk_down_regulated: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_mode == SDAC_MODE_DOWN && i_regulator_enable
      |-> o_power.bandgap_on && o_power.common_mode_on && !o_power.gain_amp_on)
    else $error("regulated power-down supplies wrong");

  chk_regulator_follow: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_power.regulator_on == i_regulator_enable)
    else $error("regulator enable not followed");

  chk_ref_pair: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_power.external_ref == ctl0_q[`SDAC_BIT_REFSEL])
    else $error("reference pair select not followed");

  chk_buffer_bypass: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !ctl1_q[`SDAC_BIT_NBUF] || !ctl1_q[`SDAC_BIT_PBUF]
      |-> !(o_power.neg_ref_buffer_on && o_power.pos_ref_buffer_on))
    else $error("buffer engaged while its enable is clear");

  chk_double_sel: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_power.factor_a_double != ctl1_q[`SDAC_BIT_CHOP1])
    else $error("doubling does not follow factor_a factor");

  chk_result_update: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    eoc_set |=> result_q == $past(i_filter_data))
    else $error("result not overwritten by new conversion");

  chk_mod_spacing: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_modulator_clk_en && (div_code != `SDAC_DIV_BYPASS) && $stable(div_code)
      |=> !o_modulator_clk_en)
    else $error("divided modulator clock pulses too close");

  chk_conv_gated: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    o_conversion_clk_en |-> $past(o_modulator_clk_en))
    else $error("conversion clock without modulator clock");

  chk_done_on_tick: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    conv_done_q |-> $past(o_conversion_clk_en) && $past(running))
    else $error("conversion ended off a conversion clock");

  chk_rdata_idle: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    !$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data outside read answer cycle");
endmodule : sdac_ctrl

// file: tb/sdac_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sdac_defs.svh"
module sdac_ctrl_test;
  import sdac_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  sdac_bus_t bus = '0;
  logic reg_en = 1'b0;
  logic [23:0] fdata = 24'h00_0000;
  logic [7:0] rdata;
  sdac_mode_t mode;
  sdac_mode_t exp_mode;
  sdac_power_t pwr;
  logic mod_en, conv_en, irq, act;
  int err_count = 0;
  int comparisons = 0;
  int n;
  logic [4:0] dv [3] = '{5'h00, 5'h02, 5'h1f};
  logic [7:0] cf [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
  sdac_ctrl dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
    .i_regulator_enable(reg_en), .i_filter_data(fdata), .o_mode(mode), .o_power(pwr),
    .o_modulator_clk_en(mod_en), .o_conversion_clk_en(conv_en), .o_irq_request(irq));
  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string msg);
    @(posedge i_core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    bus <= '0;
    #1 chk(rdata, exp, msg);
  endtask : rd
  // cycles until the chosen pulse, capped at 3200
  task automatic gap(input int sel, output int cnt);
    logic p;
    cnt = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      cnt++;
      p = (sel == 0) ? mod_en : (sel == 1) ? conv_en : irq;
    end while (p !== 1'b1 && cnt < 3200);
  endtask : gap
  initial begin
    #1_000_000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'b0;
    rd(`SDAC_ADDR_CTL0, 8'h20, "ctl0 reset");
    rd(`SDAC_ADDR_CTL1, 8'h00, "ctl1 reset");
    rd(`SDAC_ADDR_DIV, 8'h00, "div reset");
    chk(mode, SDAC_MODE_DOWN, "mode reset");
    wr(`SDAC_ADDR_CTL0, 8'hff);
    chk(mode, SDAC_MODE_DOWN, "off wins");
    rd(`SDAC_ADDR_CTL0, 8'hfd, "ctl0 bits");
    wr(`SDAC_ADDR_CTL1, 8'hfd);
    rd(`SDAC_ADDR_CTL1, 8'hfc, "ctl1 bits");
    wr(`SDAC_ADDR_DIV, 8'hff);
    rd(`SDAC_ADDR_DIV, 8'h1f, "div bits");
    rd(4'h7, 8'h00, "unmapped");
    for (int i = 0; i < 16; i++) begin
      reg_en <= i[3];
      wr(`SDAC_ADDR_CTL0, {i[0], i[1], i[2], 4'h0, i[3]});
      exp_mode = i[2] ? SDAC_MODE_DOWN : i[1] ? SDAC_MODE_SLEEP :
        i[0] ? SDAC_MODE_RESET : SDAC_MODE_NORMAL;
      act = !i[2] || i[3];
      chk(mode, exp_mode, "mode");
      chk({pwr.bandgap_on, pwr.regulator_on, pwr.common_mode_on}, {act, i[3], act}, "sup");
      chk({pwr.gain_amp_on, pwr.modulator_on}, {!i[2], !i[2] && !i[1]}, "analog");
      chk(pwr.filter_reset, exp_mode == SDAC_MODE_RESET, "sinc rst");
      chk(pwr.external_ref, i[3], "ref");
    end
    wr(`SDAC_ADDR_CHAN, 8'hcc);
    wr(`SDAC_ADDR_CTL1, 8'h18);
    wr(`SDAC_ADDR_CTL0, 8'h00);
    chk({pwr.temp_sensor_on, pwr.neg_ref_buffer_on, pwr.pos_ref_buffer_on}, 3'h7, "on");
    chk(pwr.factor_a_double, 1'b1, "double");
    wr(`SDAC_ADDR_CTL0, 8'h40);
    chk({pwr.temp_sensor_on, pwr.neg_ref_buffer_on, pwr.pos_ref_buffer_on}, 3'h0, "slp");
    wr(`SDAC_ADDR_CTL1, 8'h88);
    wr(`SDAC_ADDR_CTL0, 8'h1c);
    chk({pwr.neg_ref_buffer_on, pwr.pos_ref_buffer_on}, 2'h1, "buf");
    chk(pwr.factor_a_double, 1'b0, "single");
    wr(`SDAC_ADDR_CHAN, 8'h00);
    chk(pwr.temp_sensor_on, 1'b0, "no temp");
    foreach (dv[k]) begin
      wr(`SDAC_ADDR_DIV, {3'h0, dv[k]});
      gap(0, n);
      gap(0, n);
      chk(n, (dv[k] == 5'h1f) ? 1 : 2 * (dv[k] + 1), "mod period");
    end
    foreach (cf[k]) begin
      wr(`SDAC_ADDR_CTL1, cf[k]);
      gap(1, n);
      gap(1, n);
      chk(n, cf[k][6] ? 12 : 30, "conv period");
    end
    fdata <= 24'h12_3456;
    gap(2, n);
    gap(2, n);
    chk(n, 128 * 12, "result period");
    rd(`SDAC_ADDR_CTL1, 8'hc2, "end flag");
    rd(`SDAC_ADDR_RES_LO, 8'h56, "res lo");
    rd(`SDAC_ADDR_RES_MID, 8'h34, "res mid");
    rd(`SDAC_ADDR_RES_HI, 8'h12, "res hi");
    wr(`SDAC_ADDR_CTL1, 8'hc4);
    fdata <= 24'h65_4321;
    gap(2, n);
    chk(n, 3200, "held irq");
    rd(`SDAC_ADDR_CTL1, 8'hc4, "held flag");
    rd(`SDAC_ADDR_RES_LO, 8'h56, "held res");
    wr(`SDAC_ADDR_CTL1, 8'hc0);
    gap(2, n);
    gap(2, n);
    rd(`SDAC_ADDR_RES_LO, 8'h21, "new res");
    rd(`SDAC_ADDR_CTL1, 8'hc2, "flag stays");
    wr(`SDAC_ADDR_CTL0, 8'h18);
    gap(2, n);
    gap(2, n);
    chk(n, 256 * 12, "osr 256 period");
    wr(`SDAC_ADDR_CTL0, 8'h9c);
    gap(2, n);
    chk(n, 3200, "reset irq");
    wr(`SDAC_ADDR_CTL0, 8'h1c);
    gap(2, n);
    chk(n < 3200, 1'b1, "resume");
    wr(`SDAC_ADDR_CTL0, 8'h3c);
    chk(mode, SDAC_MODE_DOWN, "off before idle");
    conclude();
  end
endmodule : sdac_ctrl_test
